// >>> include/bsd_regs.vh
// register offsets, field positions, reset values and sizes for the blit/plane control slice
`ifndef BSD_REGS_VH
`define BSD_REGS_VH

// ----------
// register word addresses on the 8-bit register address bus
// ----------
`define BSD_OFF_BLIT_CTL_FIRST 8'h20
`define BSD_OFF_BLIT_CTL_SECOND 8'h21
`define BSD_OFF_BLIT_SIZE 8'h2c
`define BSD_OFF_DISP_PLANE_CTL 8'h40
`define BSD_OFF_ODD_PLANE_MOD 8'h44
`define BSD_OFF_EVEN_PLANE_MOD 8'h45
// plane n (1..6): high half at base + 2*(n-1), low half one above it
`define BSD_OFF_PLANE_PTR_BASE 8'h50
`define BSD_OFF_PLANE_PTR_LAST 8'h5b

// ----------
// reset values
// ----------
`define BSD_RST_WORD 16'h0000
`define BSD_RST_PTR 18'h00000

// ----------
// field positions
// ----------
// blit size
`define BSD_SIZE_H_MSB 15
`define BSD_SIZE_H_LSB 6
`define BSD_SIZE_W_MSB 5
`define BSD_SIZE_W_LSB 0
`define BSD_HEIGHT_MAX 11'h400
`define BSD_WIDTH_MAX 7'h40
`define BSD_LINE_WIDTH 6'h02
// first blit control, line mode
`define BSD_CTL0_START_MSB 15
`define BSD_CTL0_START_LSB 12
// second blit control
`define BSD_CTL1_SUD 4
`define BSD_CTL1_SUL 3
`define BSD_CTL1_AUL 2
`define BSD_CTL1_LINE 0
// display plane control
`define BSD_DPC_HIGH_RESOLUTION_SELECT 15
`define BSD_DPC_COUNT_MSB 14
`define BSD_DPC_COUNT_LSB 12
`define BSD_DPC_HAM 11
`define BSD_DPC_DUAL 10
`define BSD_DPC_COLOR 9
`define BSD_DPC_GENLOCK_AUDIO_ENABLE 8
`define BSD_DPC_LIGHT_PEN_ENABLE 3
`define BSD_DPC_INTERLACE_ENABLE 2
`define BSD_DPC_EXTERNAL_RESYNC_ENABLE 1
`define BSD_PLANE_COUNT_MAX 3'h6

// ----------
// sizes
// ----------
`define BSD_NUM_PLANES 6
`define BSD_PTR_W 18
`define BSD_PTR_HI_W 3
`define BSD_PTR_LO_W 15
`define BSD_LAUNCH_W 53
`define BSD_FIFO_DEPTH 4
`define BSD_FIFO_AW 2

`endif

// >>> rtl/bsd_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module bsd_fifo #(
    parameter WIDTH = 53,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    localparam [AW:0] FULL_CNT = DEPTH;

    // honest flags from the occupancy count
    assign in_ready = (cnt_q != FULL_CNT);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign push = in_valid & in_ready & ce;
    assign pop = out_valid & out_ready & ce;

    // storage array carries no reset, only the pointers and the count do
    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            case ({push, pop})
                2'b10: cnt_q <= cnt_q + 1'b1;
                2'b01: cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end
endmodule // bsd_fifo

// >>> rtl/bsd_top.v
// blit launch, line-draw setup, bit-plane pointers/modulos and display plane control
//
// Notes on behaviour
// - size write launches blit from held values
// - line mode: width 2, height is length
// - three direction bits select one of eight octants
// - six planes, each 18-bit advancing pointer
// - line end adds plane modulo to pointer
// - odd and even planes use separate modulos
// - control bit 15 selects high resolution
// - bits 14:12 select zero to six planes
// - control bit 11 enables hold-and-modify
// - dual playfield: odd planes first, even second
// - enable bit turns on composite colour
// - genlock audio mixed on background pin in blanking
// - bit 3 light pen, cleared at reset
// - bit 2 interlace, cleared at reset
// - bit 1 external resync, cleared at reset
// - second control bit 0 selects line mode
`timescale 1ns/100ps
`include "bsd_regs.vh"
module bsd_top (
    input wire CLK_SYS,
    input wire RST,
    input wire CE,
    // register write port, same clock as the bus logic
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [15:0] REG_DATA,
    // launched blit command towards the blitter datapath
    output reg BLIT_VALID,
    input wire BLIT_READY,
    output reg [15:0] BLIT_CTL_FIRST,
    output reg [15:0] BLIT_CTL_SECOND,
    output reg [10:0] BLIT_HEIGHT,
    output reg [6:0] BLIT_WIDTH,
    output reg BLIT_LINE_MODE,
    output reg [3:0] BLIT_START_PIXEL,
    output reg [2:0] BLIT_OCTANT,
    output reg BLIT_LINE_WIDTH_ERR,
    output reg LAUNCH_READY,
    // bit-plane fetch side
    input wire FETCH_STROBE,
    input wire [2:0] FETCH_PLANE,
    input wire LINE_END,
    input wire VBLANK,
    output reg [17:0] FETCH_ADDR,
    output reg FETCH_PLAYFIELD,
    // display control outputs
    output reg HIGH_RESOLUTION_SELECT,
    output reg [2:0] PLANE_COUNT_CODE,
    output reg [2:0] ACTIVE_PLANES,
    output reg HOLD_MODIFY_ENABLE,
    output reg DUAL_PLAYFIELD_ENABLE,
    output reg COLOR_ENABLE,
    output reg GENLOCK_AUDIO_ENABLE,
    output reg LIGHT_PEN_ENABLE,
    output reg INTERLACE_ENABLE,
    output reg EXTERNAL_RESYNC_ENABLE,
    // background pin and the audio pin that may be mixed onto it
    input wire AUDIO_PIN,
    input wire BACKGROUND_LEVEL,
    output reg BACKGROUND_PIN
);

    // ----------
    // decode helpers
    // ----------

    // direction bits to drawing octant number
    function [2:0] drawing_octant;
        input sometimes_up_down;
        input sometimes_up_left;
        input always_up_left;
        begin
            case ({sometimes_up_down, sometimes_up_left, always_up_left})
                3'b110: drawing_octant = 3'h0;
                3'b001: drawing_octant = 3'h1;
                3'b011: drawing_octant = 3'h2;
                3'b111: drawing_octant = 3'h3;
                3'b101: drawing_octant = 3'h4;
                3'b010: drawing_octant = 3'h5;
                3'b000: drawing_octant = 3'h6;
                default: drawing_octant = 3'h7;
            endcase
        end
    endfunction

    // plane number (1..6) to pointer slot, 7 means no such plane
    function [2:0] plane_slot;
        input [2:0] plane;
        begin
            if (plane >= 3'h1 && plane <= 3'h6) begin
                plane_slot = plane - 3'h1;
            end else begin
                plane_slot = 3'h7;
            end
        end
    endfunction

    // ----------
    // register state
    // ----------
    reg [15:0] blit_control_first_q;
    reg [15:0] blit_control_second_q;
    reg [15:0] odd_plane_modulo_q;
    reg [15:0] even_plane_modulo_q;
    reg [15:0] display_plane_control_q;
    wire [17:0] plane_pointer [0:`BSD_NUM_PLANES-1];
    reg launch_q;
    reg [`BSD_LAUNCH_W-1:0] launch_word_q;
    reg [1:0] audio_sync_q;

    wire [2:0] fetch_slot;
    wire fetch_active;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [`BSD_LAUNCH_W-1:0] fifo_out_data;
    wire [2:0] count_code;
    wire [2:0] clamped_count;

    // register selects; every register here is write-only
    wire wr_ctl_first = REG_WR & (REG_ADDR == `BSD_OFF_BLIT_CTL_FIRST);
    wire wr_ctl_second = REG_WR & (REG_ADDR == `BSD_OFF_BLIT_CTL_SECOND);
    wire wr_size = REG_WR & (REG_ADDR == `BSD_OFF_BLIT_SIZE);
    wire wr_dpc = REG_WR & (REG_ADDR == `BSD_OFF_DISP_PLANE_CTL);
    wire wr_odd_mod = REG_WR & (REG_ADDR == `BSD_OFF_ODD_PLANE_MOD);
    wire wr_even_mod = REG_WR & (REG_ADDR == `BSD_OFF_EVEN_PLANE_MOD);

    // size fields; zero in a field means the full count
    wire [9:0] size_height = REG_DATA[`BSD_SIZE_H_MSB:`BSD_SIZE_H_LSB];
    wire [5:0] size_width = REG_DATA[`BSD_SIZE_W_MSB:`BSD_SIZE_W_LSB];
    wire [10:0] eff_height = (size_height == 10'h000) ? `BSD_HEIGHT_MAX
                                                 : {1'b0, size_height};
    wire [6:0] eff_width = (size_width == 6'h00) ? `BSD_WIDTH_MAX
                                             : {1'b0, size_width};
    wire line_mode_now = blit_control_second_q[`BSD_CTL1_LINE];

    // ----------
    // blit control registers
    // ----------

    // control words are held until overwritten; a launch samples them
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            blit_control_first_q <= `BSD_RST_WORD;
            blit_control_second_q <= `BSD_RST_WORD;
        end else if (CE) begin
            if (wr_ctl_first) begin
                blit_control_first_q <= REG_DATA;
            end
            if (wr_ctl_second) begin
                blit_control_second_q <= REG_DATA;
            end
        end
    end

    // ----------
    // launch on size write
    // ----------

    // a size write alone starts the blit, using whatever setup is held;
    // writing size before the setup would launch with stale values
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            launch_q <= 1'b0;
            launch_word_q <= {`BSD_LAUNCH_W{1'b0}};
        end else if (CE) begin
            launch_q <= wr_size;
            if (wr_size) begin
                launch_word_q <= {blit_control_first_q, blit_control_second_q,
                                  eff_height, eff_width, line_mode_now,
                                  (line_mode_now && size_width != `BSD_LINE_WIDTH),
                                  1'b0};
            end
        end
    end

    // queue of launches; a launch into a full queue is dropped, so software
    // should poll the ready flag before writing size again
    bsd_fifo #(
        .WIDTH(`BSD_LAUNCH_W),
        .DEPTH(`BSD_FIFO_DEPTH),
        .AW(`BSD_FIFO_AW)
    ) u_launch_fifo (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .in_valid(launch_q),
        .in_ready(fifo_in_ready),
        .in_data(launch_word_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // output stage takes a new command when empty or being consumed
    assign fifo_out_ready = ~BLIT_VALID | BLIT_READY;

    // registered command outputs towards the blitter
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            BLIT_VALID <= 1'b0;
            BLIT_CTL_FIRST <= `BSD_RST_WORD;
            BLIT_CTL_SECOND <= `BSD_RST_WORD;
            BLIT_HEIGHT <= 11'h000;
            BLIT_WIDTH <= 7'h00;
            BLIT_LINE_MODE <= 1'b0;
            BLIT_START_PIXEL <= 4'h0;
            BLIT_OCTANT <= 3'h0;
            BLIT_LINE_WIDTH_ERR <= 1'b0;
            LAUNCH_READY <= 1'b1;
        end else if (CE) begin
            LAUNCH_READY <= fifo_in_ready;
            if (fifo_out_ready) begin
                BLIT_VALID <= fifo_out_valid;
                if (fifo_out_valid) begin
                    BLIT_CTL_FIRST <= fifo_out_data[52:37];
                    BLIT_CTL_SECOND <= fifo_out_data[36:21];
                    BLIT_HEIGHT <= fifo_out_data[20:10];
                    BLIT_WIDTH <= fifo_out_data[9:3];
                    BLIT_LINE_MODE <= fifo_out_data[2];
                    BLIT_LINE_WIDTH_ERR <= fifo_out_data[1];
                    // start pixel and octant only mean something in line mode
                    if (fifo_out_data[2]) begin
                        BLIT_START_PIXEL <= fifo_out_data[37+`BSD_CTL0_START_MSB:
                                                          37+`BSD_CTL0_START_LSB];
                        BLIT_OCTANT <= drawing_octant(fifo_out_data[21+`BSD_CTL1_SUD],
                                                      fifo_out_data[21+`BSD_CTL1_SUL],
                                                      fifo_out_data[21+`BSD_CTL1_AUL]);
                    end else begin
                        BLIT_START_PIXEL <= 4'h0;
                        BLIT_OCTANT <= 3'h0;
                    end
                end
            end
        end
    end

    // ----------
    // display plane control and modulos
    // ----------

    // reset clears the whole control word, light pen, interlace, resync among it
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            display_plane_control_q <= `BSD_RST_WORD;
            odd_plane_modulo_q <= `BSD_RST_WORD;
            even_plane_modulo_q <= `BSD_RST_WORD;
        end else if (CE) begin
            if (wr_dpc) begin
                display_plane_control_q <= REG_DATA;
            end
            if (wr_odd_mod) begin
                odd_plane_modulo_q <= REG_DATA;
            end
            if (wr_even_mod) begin
                even_plane_modulo_q <= REG_DATA;
            end
        end
    end

    // the unused code 7 is clamped to six planes rather than seven
    assign count_code = display_plane_control_q[`BSD_DPC_COUNT_MSB:`BSD_DPC_COUNT_LSB];
    assign clamped_count = (count_code > `BSD_PLANE_COUNT_MAX) ? `BSD_PLANE_COUNT_MAX
                                                               : count_code;

    // registered copies of the control fields
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            HIGH_RESOLUTION_SELECT <= 1'b0;
            PLANE_COUNT_CODE <= 3'h0;
            ACTIVE_PLANES <= 3'h0;
            HOLD_MODIFY_ENABLE <= 1'b0;
            DUAL_PLAYFIELD_ENABLE <= 1'b0;
            COLOR_ENABLE <= 1'b0;
            GENLOCK_AUDIO_ENABLE <= 1'b0;
            LIGHT_PEN_ENABLE <= 1'b0;
            INTERLACE_ENABLE <= 1'b0;
            EXTERNAL_RESYNC_ENABLE <= 1'b0;
        end else if (CE) begin
            HIGH_RESOLUTION_SELECT <= display_plane_control_q[`BSD_DPC_HIGH_RESOLUTION_SELECT];
            PLANE_COUNT_CODE <= count_code;
            ACTIVE_PLANES <= clamped_count;
            HOLD_MODIFY_ENABLE <= display_plane_control_q[`BSD_DPC_HAM];
            DUAL_PLAYFIELD_ENABLE <= display_plane_control_q[`BSD_DPC_DUAL];
            COLOR_ENABLE <= display_plane_control_q[`BSD_DPC_COLOR];
            GENLOCK_AUDIO_ENABLE <= display_plane_control_q[`BSD_DPC_GENLOCK_AUDIO_ENABLE];
            LIGHT_PEN_ENABLE <= display_plane_control_q[`BSD_DPC_LIGHT_PEN_ENABLE];
            INTERLACE_ENABLE <= display_plane_control_q[`BSD_DPC_INTERLACE_ENABLE];
            EXTERNAL_RESYNC_ENABLE <= display_plane_control_q[`BSD_DPC_EXTERNAL_RESYNC_ENABLE];
        end
    end

    // ----------
    // bit-plane pointers
    // ----------
    assign fetch_slot = plane_slot(FETCH_PLANE);
    assign fetch_active = (fetch_slot != 3'h7) && (FETCH_PLANE <= clamped_count);

    // one pointer per plane; a register write beats a fetch or line-end
    // step in the same cycle so a reload in blanking is never lost
    genvar gi;
    generate
        for (gi = 0; gi < `BSD_NUM_PLANES; gi = gi + 1) begin : g_plane
            wire wr_hi;
            wire wr_lo;
            wire [17:0] mod_ext;
            reg [17:0] ptr_q;
            assign plane_pointer[gi] = ptr_q;
            assign wr_hi = REG_WR & (REG_ADDR == (`BSD_OFF_PLANE_PTR_BASE + 2 * gi));
            assign wr_lo = REG_WR & (REG_ADDR == (`BSD_OFF_PLANE_PTR_BASE + 2 * gi + 1));
            // slot 0 is plane 1, so even slots are odd planes
            assign mod_ext = (gi % 2 == 0) ? {{2{odd_plane_modulo_q[15]}}, odd_plane_modulo_q}
                                           : {{2{even_plane_modulo_q[15]}},
                                              even_plane_modulo_q};
            always @(posedge CLK_SYS or posedge RST) begin
                if (RST) begin
                    ptr_q <= `BSD_RST_PTR;
                end else if (CE) begin
                    if (wr_hi || wr_lo) begin
                        // software reload, expected each vertical blank
                        if (wr_hi) begin
                            ptr_q[17:15] <= REG_DATA[2:0];
                        end
                        if (wr_lo) begin
                            ptr_q[14:0] <= REG_DATA[14:0];
                        end
                    end else if (LINE_END && gi < clamped_count) begin
                        ptr_q <= ptr_q + mod_ext;
                    end else if (FETCH_STROBE && fetch_active && fetch_slot == gi) begin
                        ptr_q <= ptr_q + 18'h00001;
                    end
                end
            end
        end
    endgenerate

    // address and playfield of the plane being fetched this cycle
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            FETCH_ADDR <= `BSD_RST_PTR;
            FETCH_PLAYFIELD <= 1'b0;
        end else if (CE) begin
            if (FETCH_STROBE && fetch_active) begin
                FETCH_ADDR <= plane_pointer[fetch_slot];
                // with dual playfield on, even planes belong to the second playfield
                FETCH_PLAYFIELD <= display_plane_control_q[`BSD_DPC_DUAL]
                                   & ~FETCH_PLANE[0];
            end
        end
    end

    // ----------
    // genlock audio on the background pin
    // ----------

    // audio arrives from a pin, so two flops before anything looks at it
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            audio_sync_q <= 2'b00;
            BACKGROUND_PIN <= 1'b0;
        end else if (CE) begin
            audio_sync_q <= {audio_sync_q[0], AUDIO_PIN};
            if (display_plane_control_q[`BSD_DPC_GENLOCK_AUDIO_ENABLE] && VBLANK) begin
                BACKGROUND_PIN <= audio_sync_q[1];
            end else begin
                BACKGROUND_PIN <= BACKGROUND_LEVEL;
            end
        end
    end

endmodule // bsd_top

// >>> tb/bsd_assertions.sv
// concurrent checks on the ports of the blit/plane control slice
`timescale 1ns/100ps
module bsd_assertions (
    input wire CLK_SYS,
    input wire RST,
    input wire CE,
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [15:0] REG_DATA,
    input wire BLIT_VALID,
    input wire BLIT_READY,
    input wire [10:0] BLIT_HEIGHT,
    input wire [6:0] BLIT_WIDTH,
    input wire FETCH_STROBE,
    input wire [2:0] FETCH_PLANE,
    input wire LINE_END,
    input wire [17:0] FETCH_ADDR,
    input wire HIGH_RESOLUTION_SELECT,
    input wire [2:0] PLANE_COUNT_CODE,
    input wire HOLD_MODIFY_ENABLE,
    input wire LIGHT_PEN_ENABLE,
    input wire INTERLACE_ENABLE,
    input wire EXTERNAL_RESYNC_ENABLE,
    input wire GENLOCK_AUDIO_ENABLE,
    input wire VBLANK,
    input wire BACKGROUND_LEVEL,
    input wire BACKGROUND_PIN
);
    // ----------
    // decodes of the inputs
    // ----------
    wire sz_wr = CE && REG_WR && REG_ADDR == 8'h2c;
    wire dc_wr = CE && REG_WR && REG_ADDR == 8'h40;
    wire f1 = CE && FETCH_STROBE && FETCH_PLANE == 3'h1 && !LINE_END && !REG_WR;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // ----------
    // properties
    // ----------
    a_size_launch: assert property ($rose(BLIT_VALID) |-> $past(sz_wr, 3))
        else $error("blit command rose without a size write");
    a_cmd_hold: assert property (BLIT_VALID && !BLIT_READY && CE |=> BLIT_VALID
        && $stable(BLIT_HEIGHT) && $stable(BLIT_WIDTH)) else $error("command not held");
    a_size_fields: assert property ($rose(BLIT_VALID) |->
        BLIT_HEIGHT == ($past(REG_DATA[15:6], 3) == 10'h0 ? 11'h400
        : {1'b0, $past(REG_DATA[15:6], 3)}) && BLIT_WIDTH == ($past(REG_DATA[5:0], 3)
        == 6'h0 ? 7'h40 : {1'b0, $past(REG_DATA[5:0], 3)})) else $error("size fields");
    a_fetch_step: assert property (f1 ##1 f1 |=> FETCH_ADDR == $past(FETCH_ADDR) + 18'h1)
        else $error("plane pointer did not advance");
    a_reset_clear: assert property ($past(RST) |-> !LIGHT_PEN_ENABLE
        && !INTERLACE_ENABLE && !EXTERNAL_RESYNC_ENABLE) else $error("bits set after reset");
    a_ctl_upper: assert property (dc_wr ##1 (CE && !dc_wr)[*2] |=>
        HIGH_RESOLUTION_SELECT == $past(REG_DATA[15], 3) && PLANE_COUNT_CODE
        == $past(REG_DATA[14:12], 3) && HOLD_MODIFY_ENABLE == $past(REG_DATA[11], 3))
        else $error("upper control bits wrong");
    a_ctl_lower: assert property (dc_wr ##1 (CE && !dc_wr)[*2] |=>
        {LIGHT_PEN_ENABLE, INTERLACE_ENABLE, EXTERNAL_RESYNC_ENABLE} == $past(REG_DATA[3:1], 3))
        else $error("lower control bits wrong");
    a_bg_follow: assert property (CE && !(GENLOCK_AUDIO_ENABLE && VBLANK) |=>
        BACKGROUND_PIN == $past(BACKGROUND_LEVEL)) else $error("background pin wrong");
    c_taken: cover property (BLIT_VALID && BLIT_READY);
    c_stalled: cover property ((BLIT_VALID && !BLIT_READY) [*3]);
    c_audio: cover property (GENLOCK_AUDIO_ENABLE && VBLANK);
endmodule // bsd_assertions

// >>> tb/bsd_blit_sink.sv
// blitter-side model: takes launched commands promptly, slowly or not at all
`timescale 1ns/100ps
module bsd_blit_sink (
    input wire clk,
    input wire rst,
    input wire valid,
    input wire [10:0] height,
    input wire stall,
    input wire slow,
    output reg ready,
    output reg [4:0] taken
);
    reg [10:0] hist [0:31];
    reg ph_q;
    // slow mode offers ready every other cycle, like a busy datapath
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ready <= 1'b0;
            ph_q <= 1'b0;
            taken <= 5'h0;
        end else begin
            ph_q <= !ph_q;
            ready <= !stall && (!slow || ph_q);
            if (valid && ready) begin
                hist[taken] <= height;
                taken <= taken + 5'h1;
            end
        end
    end
endmodule // bsd_blit_sink

// >>> tb/bsd_top_bench.sv
// self-checking bench for the blit/plane control slice
`timescale 1ns/100ps
module bsd_top_bench;
    logic CLK_SYS = 1'b0, RST = 1'b1, CE = 1'b1, REG_WR = 1'b0, FETCH_STROBE = 1'b0;
    logic LINE_END = 1'b0, VBLANK = 1'b0, AUDIO_PIN = 1'b0, BACKGROUND_LEVEL = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [15:0] REG_DATA = 16'h0000;
    logic [2:0] FETCH_PLANE = 3'h0;
    logic BLIT_VALID, BLIT_READY, BLIT_LINE_MODE, BLIT_LINE_WIDTH_ERR, LAUNCH_READY;
    logic [15:0] BLIT_CTL_FIRST, BLIT_CTL_SECOND;
    logic [10:0] BLIT_HEIGHT;
    logic [6:0] BLIT_WIDTH;
    logic [3:0] BLIT_START_PIXEL;
    logic [2:0] BLIT_OCTANT, PLANE_COUNT_CODE, ACTIVE_PLANES;
    logic [17:0] FETCH_ADDR;
    logic FETCH_PLAYFIELD, HIGH_RESOLUTION_SELECT, HOLD_MODIFY_ENABLE, DUAL_PLAYFIELD_ENABLE;
    logic COLOR_ENABLE, GENLOCK_AUDIO_ENABLE, LIGHT_PEN_ENABLE, INTERLACE_ENABLE;
    logic EXTERNAL_RESYNC_ENABLE, BACKGROUND_PIN, stall = 1'b0, slow = 1'b0;
    logic [4:0] taken;
    logic [2:0] ot [0:7] = '{3'h6, 3'h1, 3'h3, 3'h7, 3'h5, 3'h2, 3'h0, 3'h4};
    int err_count = 0, tests_run = 0, cyc = 0;
    wire [10:0] dpc = {HIGH_RESOLUTION_SELECT, PLANE_COUNT_CODE, HOLD_MODIFY_ENABLE,
        DUAL_PLAYFIELD_ENABLE, COLOR_ENABLE, GENLOCK_AUDIO_ENABLE, LIGHT_PEN_ENABLE,
        INTERLACE_ENABLE, EXTERNAL_RESYNC_ENABLE};
    bsd_top i_bsd_top (.*);
    bsd_blit_sink i_bsd_blit_sink (.clk(CLK_SYS), .rst(RST), .valid(BLIT_VALID),
        .height(BLIT_HEIGHT), .stall(stall), .slow(slow), .ready(BLIT_READY), .taken(taken));
    // ----------
    // clock, hang guard and shared tasks
    // ----------
    always #25 CLK_SYS = ~CLK_SYS;
    // tests need well under a thousand cycles, so this only trips on a hang
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK_SYS);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_DATA <= d;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
    endtask
    // size goes last so the launch sees finished setup
    task automatic go(input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] sz);
        int k;
        wr(8'h20, c0);
        wr(8'h21, c1);
        wr(8'h2c, sz);
        for (k = 0; k < 20 && BLIT_VALID !== 1'b1; k++) tick(1);
    endtask
    task automatic strobe(input logic [2:0] p, input logic [17:0] ea, input logic pf);
        @(posedge CLK_SYS);
        FETCH_STROBE <= 1'b1;
        FETCH_PLANE <= p;
        @(posedge CLK_SYS);
        FETCH_STROBE <= 1'b0;
        #1 chk({FETCH_PLAYFIELD, FETCH_ADDR[16:0]}, {pf, ea[16:0]});
        chk(FETCH_ADDR, ea);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_disp();
        wr(8'h40, 16'h6f0e);
        wr(8'h7f, 16'hffff);
        tick(3);
        chk({7'h0, dpc}, 18'h0037f);
        CE <= 1'b0;
        wr(8'h40, 16'h9000);
        CE <= 1'b1;
        wr(8'h40, 16'h9000);
        tick(3);
        chk({7'h0, dpc}, 18'h00480);
        for (int c = 0; c < 8; c++) begin
            wr(8'h40, {1'b0, c[2:0], 12'h000});
            tick(3);
            chk({15'h0, ACTIVE_PLANES}, (c == 7) ? 18'h6 : 18'(c));
        end
    endtask
    task automatic t_line();
        for (int o = 0; o < 8; o++) begin
            go({1'b1, o[2:0], 12'h000}, {11'h0, ot[o], 2'b01}, {10'(o + 1), 6'h02});
            chk({BLIT_START_PIXEL, BLIT_OCTANT, BLIT_LINE_MODE, BLIT_LINE_WIDTH_ERR},
                {9'h0, 4'(o + 8), 3'(o), 1'b1, 1'b0});
            chk({BLIT_HEIGHT, BLIT_WIDTH}, {11'(o + 1), 7'h02});
            tick(2);
        end
    endtask
    task automatic t_size();
        go(16'hf000, 16'h0000, 16'h0000);
        chk({BLIT_HEIGHT, BLIT_WIDTH}, {11'h400, 7'h40});
        chk({14'h0, BLIT_START_PIXEL}, 18'h0);
        chk({BLIT_CTL_FIRST, BLIT_CTL_SECOND[1:0]}, 18'h3c000);
        tick(2);
        go(16'h0000, 16'h0001, 16'hffff);
        chk({BLIT_HEIGHT, BLIT_WIDTH}, {11'h3ff, 7'h3f});
        chk({17'h0, BLIT_LINE_WIDTH_ERR}, 18'h1);
        tick(2);
    endtask
    task automatic t_queue();
        logic [4:0] t0;
        t0 = taken;
        stall <= 1'b1;
        for (int i = 1; i < 8; i++) wr(8'h2c, {10'(i), 6'h01});
        tick(3);
        chk({17'h0, LAUNCH_READY}, 18'h0);
        stall <= 1'b0;
        slow <= 1'b1;
        tick(40);
        chk({13'h0, 5'(taken - t0)}, 18'h5);
        for (int k = 0; k < 5; k++)
            chk({7'h0, i_bsd_blit_sink.hist[5'(t0 + k)]}, 18'(k + 1));
        slow <= 1'b0;
    endtask
    task automatic t_fetch();
        wr(8'h40, 16'h2400);
        VBLANK <= 1'b1;
        wr(8'h50, 16'h0001);
        wr(8'h51, 16'h0010);
        wr(8'h52, 16'h0000);
        wr(8'h53, 16'h0100);
        wr(8'h44, 16'h0004);
        wr(8'h45, 16'hfffe);
        VBLANK <= 1'b0;
        tick(3);
        @(posedge CLK_SYS);
        FETCH_STROBE <= 1'b1;
        FETCH_PLANE <= 3'h1;
        @(posedge CLK_SYS);
        #1 chk(FETCH_ADDR, 18'h08010);
        @(posedge CLK_SYS);
        FETCH_STROBE <= 1'b0;
        #1 chk(FETCH_ADDR, 18'h08011);
        strobe(3'h2, 18'h00100, 1'b1);
        strobe(3'h3, 18'h00100, 1'b1);
        @(posedge CLK_SYS);
        LINE_END <= 1'b1;
        @(posedge CLK_SYS);
        LINE_END <= 1'b0;
        strobe(3'h1, 18'h08016, 1'b0);
        strobe(3'h2, 18'h000ff, 1'b1);
    endtask
    task automatic t_bg();
        wr(8'h40, 16'h0100);
        VBLANK <= 1'b1;
        AUDIO_PIN <= 1'b1;
        tick(6);
        chk({17'h0, BACKGROUND_PIN}, 18'h1);
        @(posedge CLK_SYS);
        VBLANK <= 1'b0;
        tick(2);
        chk({17'h0, BACKGROUND_PIN}, 18'h0);
    endtask
    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        tick(1);
        chk({13'h0, LIGHT_PEN_ENABLE, INTERLACE_ENABLE, EXTERNAL_RESYNC_ENABLE, BLIT_VALID,
            LAUNCH_READY}, 18'h1);
        t_disp();
        t_line();
        t_size();
        t_queue();
        t_fetch();
        t_bg();
        stop_test();
    end
endmodule // bsd_top_bench
bind bsd_top bsd_assertions i_bsd_assertions (.*);
